/* verilog/usb_ep_defs.vh */
// constants for the bulk endpoint status block
// assumes a 32-bit apb slave with byte addresses
`ifndef USB_EP_DEFS_VH
`define USB_EP_DEFS_VH

`define ADDR_RX_CS 12'h000
`define ADDR_TX_CS 12'h004
`define ADDR_CTRL 12'h008
`define ADDR_ISR 12'h00c

// rx endpoint control/status bits
`define RX_SERVICE 0
`define RX_COMPLETE 1
`define RX_ERROR 2
`define RX_SENT_STALL 3
`define RX_FORCE_STALL 4
`define RX_NOT_EMPTY 5

// tx endpoint control/status bits
`define TX_SERVICE 0
`define TX_COMPLETE 1
`define TX_ERROR 2
`define TX_UNDERRUN 3
`define TX_SENT_STALL 4
`define TX_FORCE_STALL 5

// control register mask bits and isr bits
`define RX_INT_MASK 0
`define TX_INT_MASK 1
`define RX_INT_STATUS 0
`define TX_INT_STATUS 1

`define CS_RESET 8'h00
`define CTRL_RESET 2'h3

// fifo sizes and thresholds
`define RX_FIFO_DEPTH 5'd20
`define RX_SERVICE_LEVEL 5'd12
`define TX_FIFO_DEPTH 5'd16
`define TX_SERVICE_LEVEL 5'd8

// handshake codes
`define HS_ACK 2'h0
`define HS_NAK 2'h1
`define HS_STALL 2'h2

`endif

/* verilog/usb_bulk_endpoint_status.v */
// status and control of the bulk out (rx) and in (tx) endpoints
// assumes the usb engine reports token, packet and fifo events as
// one-cycle pulses on i_clock and fifo levels as same-domain counts
//
// What this block does
// - rx service flag when rx fifo holds 12+ of 20 bytes; also dma request
// - set rx complete bit 1 on full out packet; then rx interrupt if unmasked
// - write one clears rx complete; out tokens get nak while it is set
// - rx error bit 2 on crc, stuff or overrun; clears with rx complete
// - oversize out packet gets stall and sets rx sent stall bit 3; w1c
// - rx force stall bit 4 makes every out token stall until cleared
// - rx sent stall sets on entering stall; leave only when both cleared
// - read-only bit 5 shows rx fifo holds unread data
// - bits 7..6 of both endpoint registers read zero
// - tx service flag when tx fifo holds 8 or fewer of 16; also dma request
// - set tx complete bit 1 after packet sent; tx interrupt if unmasked; w1c
// - in tokens get nak while tx complete is set
// - tx error bit 2 when host gives no ack; clears with tx complete
// - underrun shortens packet, corrupts crc, sets bit 3; clears with complete
// - tx sent stall bit 4 on stall issued; clearing it flushes tx fifo
// - tx force stall bit 5 makes every in token stall until cleared
// - tx sent stall sets on entering stall; leave only when both cleared
// - a set mask bit keeps its interrupt status bit from setting
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "usb_ep_defs.vh"

module usb_bulk_endpoint_status (
  // clock and reset
  input wire i_clock,
  input wire i_nrst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // rx side of the usb engine
  input wire [4:0] i_rx_fifo_level,
  input wire i_out_token,
  input wire i_rx_packet_done,
  input wire i_rx_crc_error,
  input wire i_rx_stuff_error,
  input wire i_rx_overrun,
  input wire i_rx_oversize,
  input wire i_rx_busy,
  output reg [1:0] o_out_handshake,
  output reg o_out_handshake_valid,
  output reg o_rx_dma_req,
  // tx side of the usb engine
  input wire [4:0] i_tx_fifo_level,
  input wire i_in_token,
  input wire i_tx_packet_done,
  input wire i_tx_no_ack,
  input wire i_tx_underrun,
  input wire i_tx_busy,
  output reg [1:0] o_in_handshake,
  output reg o_in_handshake_valid,
  output reg o_tx_dma_req,
  output reg o_tx_corrupt_crc,
  output reg o_tx_flush,
  // interrupt status bits for the shared status register
  output reg o_rx_interrupt_status,
  output reg o_tx_interrupt_status
);

  reg rx_complete_reg;
  reg rx_error_reg;
  reg rx_sent_stall_reg;
  reg rx_force_stall_reg;
  reg rx_stalled_reg;
  reg tx_complete_reg;
  reg tx_error_reg;
  reg tx_underrun_reg;
  reg tx_sent_stall_reg;
  reg tx_force_stall_reg;
  reg tx_stalled_reg;
  reg [1:0] ctrl_reg;
  reg [1:0] isr_reg;
  reg rx_complete_next;
  reg rx_error_next;
  reg rx_sent_stall_next;
  reg rx_force_stall_next;
  reg rx_stalled_next;
  reg tx_complete_next;
  reg tx_error_next;
  reg tx_underrun_next;
  reg tx_sent_stall_next;
  reg tx_force_stall_next;
  reg tx_stalled_next;
  reg tx_flush_next;
  reg [1:0] ctrl_next;
  reg [1:0] isr_next;

  wire rx_service;
  wire rx_not_empty;
  wire tx_service;
  wire wr_access;
  wire rd_access;
  wire wr_rx;
  wire wr_tx;
  wire wr_ctrl;
  wire wr_isr;
  wire rx_stall_event;
  wire rx_packet_take;
  wire tx_packet_take;
  wire rx_complete_clear;
  wire rx_sent_stall_clear;
  wire tx_complete_clear;
  wire tx_sent_stall_clear;
  wire rx_int_set;
  wire tx_int_set;
  wire [7:0] rx_cs_value;
  wire [7:0] tx_cs_value;
  wire rx_enter_stall;
  wire tx_enter_stall;
  wire rx_err_event;
  reg [31:0] rdata_next;
  reg mapped;

  // fifo level flags
  assign rx_service = i_rx_fifo_level >= `RX_SERVICE_LEVEL;
  assign rx_not_empty = i_rx_fifo_level != 5'd0;
  assign tx_service = i_tx_fifo_level <= `TX_SERVICE_LEVEL;

  // zero-wait apb: a write lands on the access edge that sees pready
  assign wr_access = i_psel & i_penable & i_pwrite & o_pready;
  assign rd_access = i_psel & ~i_penable & ~i_pwrite;
  assign wr_rx = wr_access & (i_paddr == `ADDR_RX_CS);
  assign wr_tx = wr_access & (i_paddr == `ADDR_TX_CS);
  assign wr_ctrl = wr_access & (i_paddr == `ADDR_CTRL);
  assign wr_isr = wr_access & (i_paddr == `ADDR_ISR);
  // a zero written to a w1c bit leaves it alone
  assign rx_complete_clear = wr_rx & i_pwdata[`RX_COMPLETE];
  assign rx_sent_stall_clear = wr_rx & i_pwdata[`RX_SENT_STALL];
  assign tx_complete_clear = wr_tx & i_pwdata[`TX_COMPLETE];
  // flush only when a stall was really reported
  assign tx_sent_stall_clear = wr_tx & i_pwdata[`TX_SENT_STALL] & tx_sent_stall_reg;

  // forced stall is entered only while the engine is idle, so a busy
  // transaction finishes before sent stall shows
  assign rx_stall_event = i_rx_oversize & i_out_token;
  assign rx_enter_stall = rx_force_stall_reg & ~rx_stalled_reg & ~i_rx_busy;
  // the in side has no size check, so only force stall stalls it
  assign tx_enter_stall = tx_force_stall_reg & ~tx_stalled_reg & ~i_tx_busy;
  assign rx_err_event = i_rx_crc_error | i_rx_stuff_error | i_rx_overrun;
  // packets that end while stalled are dropped, not reported
  assign rx_packet_take = i_rx_packet_done & ~rx_stalled_reg;
  assign tx_packet_take = i_tx_packet_done & ~tx_stalled_reg;
  assign rx_int_set = rx_packet_take & ~ctrl_reg[`RX_INT_MASK];
  assign tx_int_set = tx_packet_take & ~ctrl_reg[`TX_INT_MASK];

  // bits 7..6 are tied low so reads of them return zero
  assign rx_cs_value[`RX_SERVICE] = rx_service;
  assign rx_cs_value[`RX_COMPLETE] = rx_complete_reg;
  assign rx_cs_value[`RX_ERROR] = rx_error_reg;
  assign rx_cs_value[`RX_SENT_STALL] = rx_sent_stall_reg;
  assign rx_cs_value[`RX_FORCE_STALL] = rx_force_stall_reg;
  assign rx_cs_value[`RX_NOT_EMPTY] = rx_not_empty;
  assign rx_cs_value[7:6] = 2'h0;
  assign tx_cs_value[`TX_SERVICE] = tx_service;
  assign tx_cs_value[`TX_COMPLETE] = tx_complete_reg;
  assign tx_cs_value[`TX_ERROR] = tx_error_reg;
  assign tx_cs_value[`TX_UNDERRUN] = tx_underrun_reg;
  assign tx_cs_value[`TX_SENT_STALL] = tx_sent_stall_reg;
  assign tx_cs_value[`TX_FORCE_STALL] = tx_force_stall_reg;
  assign tx_cs_value[7:6] = 2'h0;

  // read mux
  always @* begin
    rdata_next = 32'h0000_0000;
    mapped = 1'b1;
    case (i_paddr)
      `ADDR_RX_CS: rdata_next[7:0] = rx_cs_value;
      `ADDR_TX_CS: rdata_next[7:0] = tx_cs_value;
      `ADDR_CTRL: rdata_next[1:0] = ctrl_reg;
      `ADDR_ISR: rdata_next[1:0] = isr_reg;
      default: mapped = 1'b0;
    endcase
    // bits 7..6 and above stay zero in every case
  end

  // apb handshake
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
      if (rd_access) begin
        o_prdata <= rdata_next;
      end
    end
  end

  // rx endpoint next state; hardware set wins over software clear
  always @* begin
    rx_complete_next = rx_complete_reg;
    rx_error_next = rx_error_reg;
    rx_sent_stall_next = rx_sent_stall_reg;
    rx_force_stall_next = rx_force_stall_reg;
    rx_stalled_next = rx_stalled_reg;
    if (rx_packet_take) begin
      rx_complete_next = 1'b1;
      if (rx_err_event) begin
        rx_error_next = 1'b1;
      end
    end else if (rx_complete_clear) begin
      rx_complete_next = 1'b0;
      rx_error_next = 1'b0;
    end
    if (wr_rx) begin
      rx_force_stall_next = i_pwdata[`RX_FORCE_STALL];
    end
    if (rx_stall_event | rx_enter_stall) begin
      rx_sent_stall_next = 1'b1;
      rx_stalled_next = 1'b1;
    end else begin
      if (rx_sent_stall_clear) begin
        rx_sent_stall_next = 1'b0;
      end
      // stall is left one cycle after both bits read zero
      if (~rx_sent_stall_reg & ~rx_force_stall_reg) begin
        rx_stalled_next = 1'b0;
      end
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_complete_reg <= 1'b0;
      rx_error_reg <= 1'b0;
      rx_sent_stall_reg <= 1'b0;
      rx_force_stall_reg <= 1'b0;
      rx_stalled_reg <= 1'b0;
    end else begin
      rx_complete_reg <= rx_complete_next;
      rx_error_reg <= rx_error_next;
      rx_sent_stall_reg <= rx_sent_stall_next;
      rx_force_stall_reg <= rx_force_stall_next;
      rx_stalled_reg <= rx_stalled_next;
    end
  end

  // tx endpoint next state; hardware set wins over software clear
  always @* begin
    tx_complete_next = tx_complete_reg;
    tx_error_next = tx_error_reg;
    tx_underrun_next = tx_underrun_reg;
    tx_sent_stall_next = tx_sent_stall_reg;
    tx_force_stall_next = tx_force_stall_reg;
    tx_stalled_next = tx_stalled_reg;
    tx_flush_next = 1'b0;
    if (tx_packet_take) begin
      tx_complete_next = 1'b1;
      if (i_tx_no_ack) begin
        tx_error_next = 1'b1;
      end
      if (i_tx_underrun) begin
        tx_underrun_next = 1'b1;
      end
    end else if (tx_complete_clear) begin
      tx_complete_next = 1'b0;
      tx_error_next = 1'b0;
      tx_underrun_next = 1'b0;
    end
    if (wr_tx) begin
      tx_force_stall_next = i_pwdata[`TX_FORCE_STALL];
    end
    if (tx_enter_stall) begin
      tx_sent_stall_next = 1'b1;
      tx_stalled_next = 1'b1;
    end else begin
      if (tx_sent_stall_clear) begin
        tx_sent_stall_next = 1'b0;
        tx_flush_next = 1'b1;
      end
      if (~tx_sent_stall_reg & ~tx_force_stall_reg) begin
        tx_stalled_next = 1'b0;
      end
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_complete_reg <= 1'b0;
      tx_error_reg <= 1'b0;
      tx_underrun_reg <= 1'b0;
      tx_sent_stall_reg <= 1'b0;
      tx_force_stall_reg <= 1'b0;
      tx_stalled_reg <= 1'b0;
      o_tx_flush <= 1'b0;
    end else begin
      tx_complete_reg <= tx_complete_next;
      tx_error_reg <= tx_error_next;
      tx_underrun_reg <= tx_underrun_next;
      tx_sent_stall_reg <= tx_sent_stall_next;
      tx_force_stall_reg <= tx_force_stall_next;
      tx_stalled_reg <= tx_stalled_next;
      o_tx_flush <= tx_flush_next;
    end
  end

  // mask and interrupt status; masked events never set status
  always @* begin
    ctrl_next = ctrl_reg;
    isr_next = isr_reg;
    if (wr_ctrl) begin
      ctrl_next = i_pwdata[1:0];
    end
    if (wr_isr) begin
      isr_next = isr_reg & ~i_pwdata[1:0];
    end
    // a new event wins over a clear in the same cycle
    if (rx_int_set) begin
      isr_next[`RX_INT_STATUS] = 1'b1;
    end
    if (tx_int_set) begin
      isr_next[`TX_INT_STATUS] = 1'b1;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= `CTRL_RESET;
      isr_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      isr_reg <= isr_next;
    end
  end

  // handshake answers and registered outputs
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out_handshake <= `HS_ACK;
      o_out_handshake_valid <= 1'b0;
      o_in_handshake <= `HS_ACK;
      o_in_handshake_valid <= 1'b0;
      o_rx_dma_req <= 1'b0;
      o_tx_dma_req <= 1'b0;
      o_tx_corrupt_crc <= 1'b0;
      o_rx_interrupt_status <= 1'b0;
      o_tx_interrupt_status <= 1'b0;
    end else begin
      o_out_handshake_valid <= i_out_token;
      if (rx_stalled_reg | rx_force_stall_reg | rx_stall_event) begin
        o_out_handshake <= `HS_STALL;
      end else if (rx_complete_reg) begin
        o_out_handshake <= `HS_NAK;
      end else begin
        o_out_handshake <= `HS_ACK;
      end
      o_in_handshake_valid <= i_in_token;
      if (tx_stalled_reg | tx_force_stall_reg) begin
        o_in_handshake <= `HS_STALL;
      end else if (tx_complete_reg) begin
        o_in_handshake <= `HS_NAK;
      end else begin
        o_in_handshake <= `HS_ACK;
      end
      o_rx_dma_req <= rx_service;
      o_tx_dma_req <= tx_service;
      // engine cuts the packet short when it sees this
      o_tx_corrupt_crc <= i_tx_underrun & i_tx_busy;
      o_rx_interrupt_status <= isr_reg[`RX_INT_STATUS];
      o_tx_interrupt_status <= isr_reg[`TX_INT_STATUS];
    end
  end

endmodule

/* sim/usb_ep_checker.sv */
// port checker for the bulk endpoint status block
// bound into usb_bulk_endpoint_status; one clock, async low reset
`timescale 1ns/1ps
`include "usb_ep_defs.vh"
module usb_ep_checker (
  input wire i_clock,
  input wire i_nrst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire [4:0] i_rx_fifo_level,
  input wire [4:0] i_tx_fifo_level,
  input wire i_out_token,
  input wire i_in_token,
  input wire i_rx_oversize,
  input wire i_tx_underrun,
  input wire i_tx_busy,
  input wire [1:0] o_out_handshake,
  input wire o_out_handshake_valid,
  input wire o_in_handshake_valid,
  input wire o_rx_dma_req,
  input wire o_tx_dma_req,
  input wire o_tx_corrupt_crc,
  input wire o_tx_flush
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  rx_dma_req_a: assert property (1'b1 |=> o_rx_dma_req == $past(i_rx_fifo_level >= 5'd12))
    else $error("rx dma request wrong");
  tx_dma_req_a: assert property (1'b1 |=> o_tx_dma_req == $past(i_tx_fifo_level <= 5'd8))
    else $error("tx dma request wrong");
  out_answer_a: assert property (1'b1 |=> o_out_handshake_valid == $past(i_out_token))
    else $error("out token answer wrong");
  in_answer_a: assert property (1'b1 |=> o_in_handshake_valid == $past(i_in_token))
    else $error("in token answer wrong");
  oversize_stall_a: assert property (i_out_token && i_rx_oversize |=>
    o_out_handshake == `HS_STALL) else $error("oversize not stalled");
  crc_corrupt_a: assert property (1'b1 |=>
    o_tx_corrupt_crc == $past(i_tx_underrun && i_tx_busy)) else $error("crc corrupt wrong");
  reserved_zero_a: assert property (o_pready |-> o_prdata[31:6] == 26'h0)
    else $error("reserved bits not zero");
  flush_cause_a: assert property (o_tx_flush |-> $past(i_psel && i_penable && i_pwrite
    && i_paddr == `ADDR_TX_CS && i_pwdata[`TX_SENT_STALL])) else $error("flush without clear");
endmodule

bind usb_bulk_endpoint_status usb_ep_checker u_usb_ep_checker (.i_clock, .i_nrst, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .i_rx_fifo_level,
  .i_tx_fifo_level, .i_out_token, .i_in_token, .i_rx_oversize, .i_tx_underrun, .i_tx_busy,
  .o_out_handshake, .o_out_handshake_valid, .o_in_handshake_valid, .o_rx_dma_req,
  .o_tx_dma_req, .o_tx_corrupt_crc, .o_tx_flush);

/* sim/usb_host_model.sv */
// usb engine model: tokens and packet events toward the block
// driven by bench task calls; same clock as the block
`timescale 1ns/1ps
module usb_host_model (
  input wire i_clock,
  input wire [1:0] i_out_hs,
  input wire [1:0] i_in_hs,
  output reg o_out_tok = 1'h0,
  output reg o_rx_done = 1'h0,
  output reg o_crc = 1'h0,
  output reg o_stf = 1'h0,
  output reg o_ovr = 1'h0,
  output reg o_ovs = 1'h0,
  output reg o_in_tok = 1'h0,
  output reg o_tx_done = 1'h0,
  output reg o_nack = 1'h0,
  output reg o_unr = 1'h0
);
  // qualifiers flip once unsampled so a stale value is never trusted
  task tok(input d, input v, output [1:0] hs);
    @(posedge i_clock);
    if (d) o_in_tok <= 1'h1;
    else o_out_tok <= 1'h1;
    o_ovs <= v;
    @(posedge i_clock);
    o_in_tok <= 1'h0;
    o_out_tok <= 1'h0;
    o_ovs <= ~v;
    @(posedge i_clock);
    hs = d ? i_in_hs : i_out_hs;
  endtask
  task done(input d, input [2:0] e);
    @(posedge i_clock);
    if (d) o_tx_done <= 1'h1;
    else o_rx_done <= 1'h1;
    {o_crc, o_stf, o_ovr} <= e;
    {o_nack, o_unr} <= e[1:0];
    @(posedge i_clock);
    o_tx_done <= 1'h0;
    o_rx_done <= 1'h0;
    {o_crc, o_stf, o_ovr} <= ~e;
    {o_nack, o_unr} <= ~e[1:0];
  endtask
endmodule

/* sim/tb.sv */
// bench for the bulk endpoint status block
// apb master tasks plus the usb engine model, one 100 MHz clock
`timescale 1ns/1ps
`include "usb_ep_defs.vh"
module tb;
  reg clk = 1'h0, nrst = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, rxb = 1'h0, txb = 1'h0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwd = 32'h0, q;
  reg [4:0] rxl = 5'h0, txl = 5'h0;
  reg [1:0] hs;
  reg ep;
  wire [31:0] prd;
  wire [1:0] ohs, ihs;
  wire prdy, perr, flush, rirq, tirq, otk, rdn, crc, stf, ovr, ovs, itk, tdn, nack, unr;
  integer mismatches = 0, n_tests = 0, nflush = 0, i;
  usb_bulk_endpoint_status u_usb_bulk_endpoint_status (.i_clock(clk), .i_nrst(nrst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_rx_fifo_level(rxl),
    .i_out_token(otk), .i_rx_packet_done(rdn), .i_rx_crc_error(crc), .i_rx_stuff_error(stf),
    .i_rx_overrun(ovr), .i_rx_oversize(ovs), .i_rx_busy(rxb), .o_out_handshake(ohs),
    .o_out_handshake_valid(), .o_rx_dma_req(), .i_tx_fifo_level(txl), .i_in_token(itk),
    .i_tx_packet_done(tdn), .i_tx_no_ack(nack), .i_tx_underrun(unr), .i_tx_busy(txb),
    .o_in_handshake(ihs), .o_in_handshake_valid(), .o_tx_dma_req(), .o_tx_corrupt_crc(),
    .o_tx_flush(flush), .o_rx_interrupt_status(rirq), .o_tx_interrupt_status(tirq));
  usb_host_model u_usb_host_model (.i_clock(clk), .i_out_hs(ohs), .i_in_hs(ihs),
    .o_out_tok(otk), .o_rx_done(rdn), .o_crc(crc), .o_stf(stf), .o_ovr(ovr), .o_ovs(ovs),
    .o_in_tok(itk), .o_tx_done(tdn), .o_nack(nack), .o_unr(unr));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (flush === 1'h1) nflush <= nflush + 1;
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge clk);
    {psel, pen, paddr, pwr, pwd} <= {1'h1, 1'h0, a, w, d};
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    // no wait-state count assumed; watchdog ends a hang
    while (prdy !== 1'h1) @(posedge clk);
    q = prd;
    ep = perr;
    {psel, pen} <= 2'h0;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    apb(a, 1'h0, 32'h0);
    chk(q, e);
  endtask
  task tk(input d, input v, input [1:0] e);
    u_usb_host_model.tok(d, v, hs);
    chk({30'h0, hs}, {30'h0, e});
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    rd(`ADDR_CTRL, 32'h3);
    rd(`ADDR_RX_CS, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      {rxl, txl} <= {5'd10 + i[4:0], 5'd7 + i[4:0]};
      rd(`ADDR_RX_CS, {26'h0, 1'h1, 4'h0, i > 1});
      rd(`ADDR_TX_CS, {31'h0, i < 2});
    end
    apb(`ADDR_RX_CS, 1'h1, 32'hc1);
    rd(`ADDR_RX_CS, 32'h21);
    {rxl, txl} <= {5'd0, 5'd16};
    $display("levels test done");
    apb(`ADDR_CTRL, 1'h1, 32'h2);
    for (i = 0; i < 3; i = i + 1) begin
      u_usb_host_model.done(1'h0, 3'h1 << i);
      rd(`ADDR_RX_CS, 32'h6);
      chk(rirq, 1);
      tk(1'h0, 1'h0, `HS_NAK);
      apb(`ADDR_RX_CS, 1'h1, 32'h0);
      rd(`ADDR_RX_CS, 32'h6);
      apb(`ADDR_RX_CS, 1'h1, 32'h2);
      rd(`ADDR_RX_CS, 32'h0);
      apb(`ADDR_ISR, 1'h1, 32'h1);
    end
    tk(1'h0, 1'h0, `HS_ACK);
    apb(`ADDR_CTRL, 1'h1, 32'h3);
    u_usb_host_model.done(1'h0, 3'h0);
    rd(`ADDR_ISR, 32'h0);
    rd(`ADDR_RX_CS, 32'h2);
    rxl <= 5'd3;
    rd(`ADDR_RX_CS, 32'h22);
    rxl <= 5'd0;
    rd(`ADDR_RX_CS, 32'h2);
    apb(`ADDR_RX_CS, 1'h1, 32'h2);
    $display("rx packet test done");
    rxb <= 1'h1;
    apb(`ADDR_RX_CS, 1'h1, 32'h10);
    rd(`ADDR_RX_CS, 32'h10);
    rxb <= 1'h0;
    rd(`ADDR_RX_CS, 32'h18);
    tk(1'h0, 1'h0, `HS_STALL);
    apb(`ADDR_RX_CS, 1'h1, 32'h0);
    tk(1'h0, 1'h0, `HS_STALL);
    apb(`ADDR_RX_CS, 1'h1, 32'h8);
    tk(1'h0, 1'h0, `HS_ACK);
    tk(1'h0, 1'h1, `HS_STALL);
    rd(`ADDR_RX_CS, 32'h8);
    apb(`ADDR_RX_CS, 1'h1, 32'h8);
    $display("rx stall test done");
    apb(`ADDR_CTRL, 1'h1, 32'h1);
    txb <= 1'h1;
    u_usb_host_model.done(1'h1, 3'h3);
    txb <= 1'h0;
    rd(`ADDR_TX_CS, 32'he);
    chk(tirq, 1);
    tk(1'h1, 1'h0, `HS_NAK);
    apb(`ADDR_TX_CS, 1'h1, 32'h2);
    rd(`ADDR_TX_CS, 32'h0);
    apb(`ADDR_TX_CS, 1'h1, 32'h20);
    tk(1'h1, 1'h0, `HS_STALL);
    rd(`ADDR_TX_CS, 32'h30);
    apb(`ADDR_TX_CS, 1'h1, 32'h0);
    tk(1'h1, 1'h0, `HS_STALL);
    apb(`ADDR_TX_CS, 1'h1, 32'h10);
    tk(1'h1, 1'h0, `HS_ACK);
    chk(nflush, 1);
    $display("tx test done");
    rd(12'h010, 32'h0);
    chk(ep, 1);
    $display("unmapped test done");
    give_verdict;
  end
endmodule
